// *** ufl_pkg.sv ***
// Constants shared by the UART FIFO, line-format and modem-output control block
package ufl_pkg;
  // Register port offsets
  localparam logic [2:0] OFS_DATA  = 3'h0;
  localparam logic [2:0] OFS_IER   = 3'h1;
  localparam logic [2:0] OFS_ISR   = 3'h2;
  localparam logic [2:0] OFS_FCR   = 3'h2;
  localparam logic [2:0] OFS_LCR   = 3'h3;
  localparam logic [2:0] OFS_MCR   = 3'h4;

  // fifo_control fields
  localparam int FCR_EN     = 0;
  localparam int FCR_RXRST  = 1;
  localparam int FCR_TXRST  = 2;
  localparam int FCR_TXT_LO = 4;
  localparam int FCR_TXT_HI = 5;
  localparam int FCR_RXT_LO = 6;
  localparam int FCR_RXT_HI = 7;

  // line_format_control fields
  localparam int LCR_WL_LO  = 0;
  localparam int LCR_WL_HI  = 1;
  localparam int LCR_STOP   = 2;
  localparam int LCR_PEN    = 3;
  localparam int LCR_EVEN   = 4;
  localparam int LCR_FORCE  = 5;
  localparam int LCR_BREAK  = 6;
  localparam int LCR_DIV    = 7;
  localparam logic [7:0] LCR_RESET = 8'h1d;

  // modem_output_control fields
  localparam int MCR_DTR    = 0;
  localparam int MCR_RTS    = 1;
  localparam logic [7:0] MCR_RESET = 8'h00;

  // interrupt_source_status fields and codes
  localparam int ISR_FLOW   = 5;
  localparam int ISR_FE_LO  = 6;
  localparam int ISR_FE_HI  = 7;
  localparam logic [5:0] ISR_LSR   = 6'h06;
  localparam logic [5:0] ISR_RXTMO = 6'h0c;
  localparam logic [5:0] ISR_RXRDY = 6'h04;
  localparam logic [5:0] ISR_TXRDY = 6'h02;
  localparam logic [5:0] ISR_MSR   = 6'h00;
  localparam logic [5:0] ISR_FLOWC = 6'h20;
  localparam logic [5:0] ISR_NONE  = 6'h01;

  // Trigger levels
  localparam int TRIG_W = 7;
  localparam logic [TRIG_W-1:0] TRIG_ONE = 7'h01;
  localparam logic [TRIG_W-1:0] TX_T0 = 7'h08;
  localparam logic [TRIG_W-1:0] TX_T1 = 7'h10;
  localparam logic [TRIG_W-1:0] TX_T2 = 7'h20;
  localparam logic [TRIG_W-1:0] TX_T3 = 7'h38;
  localparam logic [TRIG_W-1:0] RX_T0 = 7'h08;
  localparam logic [TRIG_W-1:0] RX_T1 = 7'h10;
  localparam logic [TRIG_W-1:0] RX_T2 = 7'h38;
  localparam logic [TRIG_W-1:0] RX_T3 = 7'h3c;

  // FIFO reset hold, in crystal clocks (the block clock is the crystal clock)
  localparam int FIFO_RST_CLKS = 3;
endpackage : ufl_pkg

// *** ufl_hold_pulse.sv ***
// Stretches a one-cycle request into a pulse of a fixed number of clocks
`timescale 1ns/10ps
`default_nettype none
module ufl_hold_pulse
  import ufl_pkg::*;
#(
  parameter int HOLD = FIFO_RST_CLKS
) (
  input  wire logic clk_i,    // Crystal clock
  input  wire logic rst_i,    // Async reset, active high
  input  wire logic start_i,  // One-cycle request
  output logic      busy_o    // High for HOLD clocks after request
);
  localparam int CW = $clog2(HOLD + 1);
  localparam logic [CW-1:0] HOLD_CNT = CW'(HOLD);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          busy;
  } ufl_hold_t;

  ufl_hold_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    if (start_i) begin
      // A repeated request restarts the full hold
      s_next.cnt  = HOLD_CNT;
      s_next.busy = 1'b1;
    end else if (s_reg.cnt != '0) begin
      s_next.cnt  = s_reg.cnt - CW'(1);
      s_next.busy = (s_reg.cnt != CW'(1));
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy_o = s_reg.busy;
endmodule : ufl_hold_pulse
`default_nettype wire

// *** ufl_ctrl.sv ***
// UART FIFO, line-format and modem-output control with register port
// Summary of operation
// - When unlocked, CTS input or RTS output deassertion sets flow status bit.
// - Status bits 7:6 both read 1 when FIFOs enabled, else 0.
// - FIFO enable defaults 0; other FIFO fields only update when written with enable.
// - Receive FIFO reset clears pointers, held at least three clocks, self-clears.
// - Transmit FIFO reset clears pointers only, then self-clears.
// - FIFO control bit three does nothing.
// - Unlocked with FIFOs enabled, transmit trigger codes give 8,16,32,56 spaces; otherwise one.
// - Transmit interrupt when spaces exceed trigger, or FIFO empties after short reload.
// - Receive trigger codes give 8,16,56,60 characters; default one.
// - Receive interrupt when held characters exceed trigger or timeout occurs.
// - Word length codes give 5 to 8 bits; six is default.
// - Stop select: one stop, or 1.5 for five bits, two otherwise; default two.
// - Parity enable, default on, appends and checks a parity bit.
// - Parity type bit selects odd when 0, even when 1; even default.
// - Forced parity sends and expects 1 for type 0, 0 for type 1.
// - Break bit holds serial output low until cleared.
// - Divisor-access bit maps shared addresses to divisor latches instead of data.
// - Terminal-ready bit drives its active-low output low when set.
// - Send-request bit drives active-low output; auto flow or half-duplex may take it.
// - Status read returns highest-priority pending code; bit 0 set means none.
`timescale 1ns/10ps
`default_nettype none
module ufl_ctrl
  import ufl_pkg::*;
#(
  parameter int FIFO_DEPTH = 64
) (
  input  wire logic              clk_i,                      // Crystal clock, 100 MHz
  input  wire logic              rst_i,                      // Async reset, active high
  input  wire logic [2:0]        reg_addr_i,                 // Register offset
  input  wire logic              reg_wr_i,                   // Write strobe
  input  wire logic              reg_rd_i,                   // Read strobe
  input  wire logic [7:0]        reg_wdata_i,                // Write data
  output logic      [7:0]        reg_rdata_o,                // Read data, next cycle
  output logic                   data_acc_o,                 // Shared address hits data regs
  output logic                   div_acc_o,                  // Shared address hits divisor
  input  wire logic              enhanced_feature_unlock_i,  // Enhanced functions unlocked
  input  wire logic [TRIG_W-1:0] tx_space_i,                 // Free transmit FIFO spaces
  input  wire logic              tx_write_i,                 // Host wrote transmit data
  input  wire logic [TRIG_W-1:0] rx_count_i,                 // Characters in receive FIFO
  input  wire logic              rx_timeout_i,               // Receive data timeout
  input  wire logic              line_err_i,                 // Line status interrupt pending
  input  wire logic              msr_pend_i,                 // Modem status interrupt pending
  input  wire logic              msr_rd_i,                   // Host read modem status
  input  wire logic              cts_n_i,                    // Clear-to-send pin, active low
  input  wire logic              auto_flow_en_i,             // Auto hardware flow owns RTS
  input  wire logic              auto_rts_n_i,               // RTS from auto flow control
  input  wire logic              half_duplex_en_i,           // Half-duplex control owns RTS
  input  wire logic              half_duplex_rts_n_i,        // RTS from half-duplex control
  input  wire logic              tx_line_i,                  // Serial data from shifter
  output logic                   txd_o,                      // Serial transmit output
  output logic                   dtr_n_o,                    // Terminal-ready, active low
  output logic                   rts_n_o,                    // Send-request, active low
  output logic                   fifo_en_o,                  // FIFOs enabled
  output logic                   rx_fifo_rst_o,              // Receive pointer reset
  output logic                   tx_fifo_rst_o,              // Transmit pointer reset
  output logic [TRIG_W-1:0]      tx_level_o,                 // Transmit trigger, spaces
  output logic [TRIG_W-1:0]      rx_level_o,                 // Receive trigger, characters
  output logic                   tx_req_o,                   // Transmit interrupt condition
  output logic                   rx_req_o,                   // Receive interrupt condition
  output logic [1:0]             word_len_o,                 // 00..11 = 5..8 bits
  output logic                   stop_half_o,                // 1.5 stop bits
  output logic                   stop_two_o,                 // 2 stop bits
  output logic                   parity_en_o,                // Parity bit used
  output logic                   parity_odd_o,               // Odd parity
  output logic                   parity_force_o,             // Constant parity bit
  output logic                   parity_fixed_o,             // Value of constant parity
  output logic                   div_sel_o                   // Divisor latch selected
);
  localparam logic [TRIG_W-1:0] DEPTH_SP = TRIG_W'(FIFO_DEPTH);

  typedef struct packed {
    logic        fifo_en;
    logic [1:0]  tx_sel;
    logic [1:0]  rx_sel;
    logic [7:0]  line_format_control;
    logic [7:0]  modem_output_control;
    logic        tx_pend;
    logic        tx_above;
    logic        tx_empty;
    logic        rx_req;
    logic        flow_pend;
    logic [2:0]  cts_sync;
    logic        cts_stable;
    logic        rts_n;
    logic        dtr_n;
    logic        txd;
    logic [7:0]  rdata;
  } ufl_state_t;

  localparam ufl_state_t STATE_RESET = '{
    fifo_en: 1'b0, tx_sel: 2'h0, rx_sel: 2'h0, line_format_control: LCR_RESET, modem_output_control: MCR_RESET,
    tx_pend: 1'b0, tx_above: 1'b0, tx_empty: 1'b0, rx_req: 1'b0, flow_pend: 1'b0,
    cts_sync: 3'h7, cts_stable: 1'b1, rts_n: 1'b1, dtr_n: 1'b1, txd: 1'b1,
    rdata: 8'h00};

  function automatic logic [TRIG_W-1:0] tx_trig(input logic unl, input logic [1:0] sel);
    if (!unl) begin
      return TRIG_ONE;
    end
    unique case (sel)
      2'h0: return TX_T0;
      2'h1: return TX_T1;
      2'h2: return TX_T2;
      2'h3: return TX_T3;
    endcase
  endfunction : tx_trig

  function automatic logic [TRIG_W-1:0] rx_trig(input logic en, input logic [1:0] sel);
    if (!en) begin
      return TRIG_ONE;
    end
    unique case (sel)
      2'h0: return RX_T0;
      2'h1: return RX_T1;
      2'h2: return RX_T2;
      2'h3: return RX_T3;
    endcase
  endfunction : rx_trig

  ufl_state_t        s_reg, s_next;
  logic              wr_fcr, rx_rst_req, tx_rst_req, shared_hit;
  logic              cts_agree, cts_deassert, rts_sel, rts_rise, flow_set;
  logic              tx_above, tx_empty, tx_set, tx_clr, isr_rd;
  logic [TRIG_W-1:0] tx_lvl, rx_lvl;
  logic [5:0]        isr_code;

  always_comb begin
    s_next = s_reg;
    tx_lvl = tx_trig(enhanced_feature_unlock_i && s_reg.fifo_en, s_reg.tx_sel);
    rx_lvl = rx_trig(s_reg.fifo_en, s_reg.rx_sel);
    wr_fcr = reg_wr_i && (reg_addr_i == OFS_FCR);
    isr_rd = reg_rd_i && (reg_addr_i == OFS_ISR);
    // Bit three of the FIFO control write is never looked at
    if (wr_fcr) begin
      s_next.fifo_en = reg_wdata_i[FCR_EN];
      if (reg_wdata_i[FCR_EN]) begin
        s_next.rx_sel = reg_wdata_i[FCR_RXT_HI:FCR_RXT_LO];
        if (enhanced_feature_unlock_i) begin
          s_next.tx_sel = reg_wdata_i[FCR_TXT_HI:FCR_TXT_LO];
        end
      end
    end
    // Resets act only in a write that also carries the enable
    rx_rst_req = wr_fcr && reg_wdata_i[FCR_EN] && reg_wdata_i[FCR_RXRST];
    tx_rst_req = wr_fcr && reg_wdata_i[FCR_EN] && reg_wdata_i[FCR_TXRST];
    if (reg_wr_i && (reg_addr_i == OFS_LCR)) begin
      s_next.line_format_control = reg_wdata_i;
    end
    if (reg_wr_i && (reg_addr_i == OFS_MCR)) begin
      s_next.modem_output_control = reg_wdata_i;
    end

    // Clear-to-send: three stages, a change counts once stages two and three agree
    s_next.cts_sync = {s_reg.cts_sync[1:0], cts_n_i};
    cts_agree    = (s_reg.cts_sync[1] == s_reg.cts_sync[2]);
    cts_deassert = cts_agree && s_reg.cts_sync[2] && !s_reg.cts_stable;
    if (cts_agree) begin
      s_next.cts_stable = s_reg.cts_sync[2];
    end

    // Send-request ownership: auto flow first, then half-duplex, then the bit
    if (auto_flow_en_i) begin
      rts_sel = auto_rts_n_i;
    end else if (half_duplex_en_i) begin
      rts_sel = half_duplex_rts_n_i;
    end else begin
      rts_sel = ~s_next.modem_output_control[MCR_RTS];
    end
    s_next.rts_n = rts_sel;
    rts_rise     = rts_sel && !s_reg.rts_n;
    s_next.dtr_n = ~s_next.modem_output_control[MCR_DTR];
    s_next.txd   = s_next.line_format_control[LCR_BREAK] ? 1'b0 : tx_line_i;

    // Flow status: set wins over the modem status read that clears it
    flow_set = enhanced_feature_unlock_i && (cts_deassert || rts_rise);
    s_next.flow_pend = flow_set || (s_reg.flow_pend && !msr_rd_i);

    // Transmit ready: a fresh crossing above the level or a fresh empty sets it;
    // a reload that never filled past the level keeps tx_above high, so only the
    // empty edge can raise it again
    tx_above = (tx_space_i > tx_lvl);
    tx_empty = (tx_space_i == DEPTH_SP);
    s_next.tx_above = tx_above;
    s_next.tx_empty = tx_empty;
    tx_set = (tx_above && !s_reg.tx_above) || (tx_empty && !s_reg.tx_empty);
    s_next.rx_req = rx_timeout_i || (rx_count_i > rx_lvl);

    if (!s_reg.fifo_en && s_reg.line_format_control[LCR_DIV]) begin
      isr_code = ISR_NONE;
    end
    if (line_err_i) begin
      isr_code = ISR_LSR;
    end else if (rx_timeout_i) begin
      isr_code = ISR_RXTMO;
    end else if (rx_count_i > rx_lvl) begin
      isr_code = ISR_RXRDY;
    end else if (s_reg.tx_pend) begin
      isr_code = ISR_TXRDY;
    end else if (msr_pend_i) begin
      isr_code = ISR_MSR;
    end else if (s_reg.flow_pend) begin
      isr_code = ISR_FLOWC;
    end else begin
      isr_code = ISR_NONE;
    end
    isr_code[ISR_FLOW] = s_reg.flow_pend;

    tx_clr = tx_write_i || (isr_rd && (isr_code == ISR_TXRDY));
    s_next.tx_pend = tx_set || (s_reg.tx_pend && !tx_clr);

    if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFS_ISR: s_next.rdata = {{2{s_reg.fifo_en}}, isr_code};
        OFS_LCR: s_next.rdata = s_reg.line_format_control;
        OFS_MCR: s_next.rdata = s_reg.modem_output_control;
        default: s_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  ufl_hold_pulse #(.HOLD(FIFO_RST_CLKS)) u_rx_rst (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (rx_rst_req),
    .busy_o  (rx_fifo_rst_o)
  );

  ufl_hold_pulse #(.HOLD(FIFO_RST_CLKS)) u_tx_rst (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (tx_rst_req),
    .busy_o  (tx_fifo_rst_o)
  );

  assign shared_hit  = (reg_rd_i || reg_wr_i) && ((reg_addr_i == OFS_DATA) || (reg_addr_i == OFS_IER));
  assign div_acc_o   = shared_hit && s_reg.line_format_control[LCR_DIV];
  assign data_acc_o  = shared_hit && !s_reg.line_format_control[LCR_DIV];
  assign div_sel_o   = s_reg.line_format_control[LCR_DIV];
  assign reg_rdata_o = s_reg.rdata;
  assign txd_o       = s_reg.txd;
  assign dtr_n_o     = s_reg.dtr_n;
  assign rts_n_o     = s_reg.rts_n;
  assign fifo_en_o   = s_reg.fifo_en;
  assign tx_level_o  = tx_lvl;
  assign rx_level_o  = rx_lvl;
  assign tx_req_o    = s_reg.tx_pend;
  assign rx_req_o    = s_reg.rx_req;
  assign word_len_o  = s_reg.line_format_control[LCR_WL_HI:LCR_WL_LO];
  assign stop_two_o  = s_reg.line_format_control[LCR_STOP] && (word_len_o != 2'h0);
  assign stop_half_o = s_reg.line_format_control[LCR_STOP] && (word_len_o == 2'h0);
  assign parity_en_o    = s_reg.line_format_control[LCR_PEN];
  assign parity_odd_o   = !s_reg.line_format_control[LCR_EVEN];
  assign parity_force_o = s_reg.line_format_control[LCR_FORCE];
  assign parity_fixed_o = !s_reg.line_format_control[LCR_EVEN];

  a_flow_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (enhanced_feature_unlock_i && rts_rise) |=> s_reg.flow_pend)
    else $error("flow status not set on deassertion");
  a_fifo_status: assert property (@(posedge clk_i) disable iff (rst_i)
    isr_rd |=> (reg_rdata_o[ISR_FE_HI:ISR_FE_LO] == {2{$past(s_reg.fifo_en)}}))
    else $error("FIFO enable status wrong");
  a_fcr_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_fcr && !reg_wdata_i[FCR_EN]) |=> ($stable(s_reg.rx_sel) && !s_reg.fifo_en && !rx_fifo_rst_o))
    else $error("FIFO fields changed without enable");
  a_rx_reset_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_rst_req |=> rx_fifo_rst_o [*3] ##1 (!rx_fifo_rst_o || $past(rx_rst_req, 3)))
    else $error("receive reset not held three clocks");
  a_tx_reset_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_rst_req |=> tx_fifo_rst_o ##1 tx_fifo_rst_o)
    else $error("transmit reset missing");
  a_tx_level: assert property (@(posedge clk_i) disable iff (rst_i)
    (enhanced_feature_unlock_i && s_reg.fifo_en && (s_reg.tx_sel == 2'h3)) |-> (tx_level_o == 7'h38))
    else $error("transmit trigger not 56");
  a_tx_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_fcr && !enhanced_feature_unlock_i) |=> $stable(s_reg.tx_sel))
    else $error("transmit trigger written while locked");
  a_tx_pend: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_empty && !s_reg.tx_empty) |=> tx_req_o)
    else $error("transmit interrupt missing on empty");
  a_rx_req: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_reg.fifo_en && (s_reg.rx_sel == 2'h3) && (rx_count_i > 7'h3c)) |=> rx_req_o)
    else $error("receive interrupt missing above 60");
  a_break_low: assert property (@(posedge clk_i) disable iff (rst_i)
    s_next.line_format_control[LCR_BREAK] |=> !txd_o)
    else $error("break does not hold output low");
  a_dtr_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    (reg_wr_i && (reg_addr_i == OFS_MCR)) |=> (dtr_n_o == !$past(reg_wdata_i[MCR_DTR])))
    else $error("terminal-ready output wrong");
  a_div_map: assert property (@(posedge clk_i) disable iff (rst_i)
    (reg_wr_i && (reg_addr_i == OFS_DATA)) |-> (div_acc_o != data_acc_o) && (div_acc_o == s_reg.line_format_control[LCR_DIV]))
    else $error("shared address mapping wrong");
  a_isr_none: assert property (@(posedge clk_i) disable iff (rst_i)
    (isr_rd && !line_err_i && !rx_timeout_i && !s_reg.tx_pend && !msr_pend_i && !s_reg.flow_pend
      && !(rx_count_i > rx_lvl)) |=> reg_rdata_o[0])
    else $error("status read shows pending with none");
  a_force_par: assert property (@(posedge clk_i) disable iff (rst_i)
    (parity_en_o && parity_force_o && !s_reg.line_format_control[LCR_EVEN]) |-> parity_fixed_o)
    else $error("forced parity not mark");
endmodule : ufl_ctrl
`default_nettype wire

// *** ufl_remote.sv ***
// Remote serial device model: drives clear-to-send and watches the line for a break
`timescale 1ns/10ps
`default_nettype none
module ufl_remote (
  input  wire logic clk_i,       // Crystal clock
  input  wire logic rst_i,       // Async reset, active high
  input  wire logic hold_off_i,  // Bench asks the remote end to stop the device
  input  wire logic txd_i,       // Serial line from the device
  output logic      cts_n_o,     // Clear-to-send, active low
  output logic      break_o      // Line seen low for a whole frame
);
  logic [3:0] low_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_reg <= 4'h0;
      cts_n_o <= 1'b1;
    end else begin
      cts_n_o <= hold_off_i;
      low_reg <= txd_i ? 4'h0 : ((low_reg == 4'hf) ? low_reg : low_reg + 4'h1);
    end
  end
  // A frame is taken as ten clocks; the real bit rate lies outside this block
  assign break_o = (low_reg >= 4'ha);
endmodule : ufl_remote
`default_nettype wire

// *** ufl_ctrl_tb.sv ***
// Self-checking bench for the FIFO, line-format and modem-output control block
`timescale 1ns/10ps
`default_nettype none
module ufl_ctrl_tb;
  import ufl_pkg::*;
  logic              clk_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0, unl = 1'b0, tmo = 1'b0;
  logic              lerr = 1'b0, msr_rd = 1'b0, hdx = 1'b0, hold = 1'b0, txw = 1'b0, msrp = 1'b0;
  logic [2:0]        addr = 3'h0;
  logic [7:0]        wd = 8'h00, q, rdata;
  logic [TRIG_W-1:0] spc = 7'h00, cnt = 7'h00, txl, rxl;
  logic              dacc, vacc, txd, dtr_n, rts_n, fen, rxr, txr, txq, rxq, sh, s2, pen, podd, pfo, pfx, dsel;
  logic              cts_n, brk;
  logic [1:0]        wl;
  logic [TRIG_W-1:0] txt [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
  logic [TRIG_W-1:0] rxt [4] = '{7'h08, 7'h10, 7'h38, 7'h3c};
  logic [7:0]        lv [4] = '{8'h0c, 8'h19, 8'h2e, 8'h3b};
  int                n_mismatch = 0, n_checks = 0;

  ufl_ctrl u_ufl_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd),
    .reg_rdata_o(rdata), .data_acc_o(dacc), .div_acc_o(vacc), .enhanced_feature_unlock_i(unl),
    .tx_space_i(spc), .tx_write_i(txw), .rx_count_i(cnt), .rx_timeout_i(tmo), .line_err_i(lerr),
    .msr_pend_i(msrp), .msr_rd_i(msr_rd), .cts_n_i(cts_n), .auto_flow_en_i(1'b0), .auto_rts_n_i(1'b1),
    .half_duplex_en_i(hdx), .half_duplex_rts_n_i(hdx), .tx_line_i(1'b1), .txd_o(txd), .dtr_n_o(dtr_n),
    .rts_n_o(rts_n), .fifo_en_o(fen), .rx_fifo_rst_o(rxr), .tx_fifo_rst_o(txr), .tx_level_o(txl),
    .rx_level_o(rxl), .tx_req_o(txq), .rx_req_o(rxq), .word_len_o(wl), .stop_half_o(sh), .stop_two_o(s2),
    .parity_en_o(pen), .parity_odd_o(podd), .parity_force_o(pfo), .parity_fixed_o(pfx), .div_sel_o(dsel));
  ufl_remote u_ufl_remote (.clk_i(clk_i), .rst_i(rst_i), .hold_off_i(hold), .txd_i(txd), .cts_n_o(cts_n),
    .break_o(brk));

  always #5 clk_i = ~clk_i;

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // One register access; read data is taken one cycle after the strobe
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr = a;
    wd = d;
    wr = w;
    rd = !w;
    @(negedge clk_i);
    wr = 1'b0;
    rd = 1'b0;
    q = rdata;
  endtask : acc

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // Whole run is well under a thousand cycles
  initial begin
    #100us;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    acc(1'b0, OFS_LCR, 8'h00);
    chk("lcr", q, 8'h1d);
    chk("s2", s2, 1'b1);
    chk("podd", podd, 1'b0);
    acc(1'b0, OFS_MCR, 8'h00);
    chk("mcr", q, 8'h00);
    chk("dtr", dtr_n, 1'b1);
    chk("rts", rts_n, 1'b1);
    acc(1'b0, OFS_ISR, 8'h00);
    chk("isr", q, 8'h01);
    chk("rxl", rxl, 7'h01);
    $display("reset test done");
    acc(1'b1, OFS_FCR, 8'hcf);
    chk("fen", fen, 1'b1);
    chk("rxr", rxr, 1'b1);
    chk("txr", txr, 1'b1);
    chk("rxl", rxl, 7'h3c);
    chk("txl", txl, 7'h01);
    repeat (2) @(negedge clk_i);
    chk("rxr", rxr, 1'b1);
    @(negedge clk_i);
    chk("rxr", rxr, 1'b0);
    chk("txr", txr, 1'b0);
    acc(1'b0, OFS_ISR, 8'h00);
    chk("isr", q, 8'hc1);
    acc(1'b1, OFS_FCR, 8'h06);
    chk("fen", fen, 1'b0);
    chk("rxr", rxr, 1'b0);
    acc(1'b0, OFS_ISR, 8'h00);
    chk("isr", q, 8'h01);
    $display("fifo control test done");
    acc(1'b1, OFS_MCR, 8'h03);
    chk("dtr", dtr_n, 1'b0);
    chk("rts", rts_n, 1'b0);
    hdx = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("rts", rts_n, 1'b1);
    hdx = 1'b0;
    acc(1'b1, OFS_MCR, 8'h00);
    chk("dtr", dtr_n, 1'b1);
    $display("modem output test done");
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, OFS_LCR, lv[i]);
      chk("wl", wl, lv[i][1:0]);
      chk("sh", sh, lv[i][2] && lv[i][1:0] == 2'b00);
      chk("s2", s2, lv[i][2] && lv[i][1:0] != 2'b00);
      chk("pen", pen, 1'b1);
      chk("pfo", pfo, lv[i][5]);
      if (lv[i][5]) chk("pfx", pfx, !lv[i][4]);
      else chk("podd", podd, !lv[i][4]);
    end
    acc(1'b1, OFS_LCR, 8'h40);
    repeat (12) @(negedge clk_i);
    chk("brk", brk, 1'b1);
    acc(1'b1, OFS_LCR, 8'h03);
    @(negedge clk_i);
    chk("txd", txd, 1'b1);
    chk("pen", pen, 1'b0);
    for (int d = 1; d >= 0; d--) begin
      acc(1'b1, OFS_LCR, {d[0], 7'h03});
      chk("dsel", dsel, d[0]);
      @(negedge clk_i);
      rd = 1'b1;
      addr = OFS_DATA;
      #1 chk("divacc", vacc, d[0]);
      chk("dacc", dacc, !d[0]);
      @(negedge clk_i);
      rd = 1'b0;
    end
    $display("line format test done");
    unl = 1'b1;
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, OFS_FCR, {2'(i), 2'(i), 4'h1});
      chk("txl", txl, txt[i]);
      chk("rxl", rxl, rxt[i]);
    end
    unl = 1'b0;
    acc(1'b1, OFS_FCR, 8'h01);
    chk("txl", txl, 7'h01);
    unl = 1'b1;
    @(negedge clk_i);
    chk("txl", txl, 7'h38);
    acc(1'b1, OFS_FCR, 8'h01);
    spc = 7'h08;
    @(negedge clk_i);
    spc = 7'h09;
    repeat (2) @(negedge clk_i);
    chk("txq", txq, 1'b1);
    acc(1'b0, OFS_ISR, 8'h00);
    chk("isr", q, 8'hc2);
    chk("txq", txq, 1'b0);
    spc = 7'h40;
    repeat (2) @(negedge clk_i);
    chk("txq", txq, 1'b1);
    txw = 1'b1;
    @(negedge clk_i);
    txw = 1'b0;
    chk("txq", txq, 1'b0);
    cnt = 7'h08;
    repeat (2) @(negedge clk_i);
    chk("rxq", rxq, 1'b0);
    cnt = 7'h09;
    repeat (2) @(negedge clk_i);
    chk("rxq", rxq, 1'b1);
    acc(1'b0, OFS_ISR, 8'h00);
    chk("isr", q, 8'hc4);
    cnt = 7'h00;
    tmo = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("rxq", rxq, 1'b1);
    acc(1'b0, OFS_ISR, 8'h00);
    chk("isr", q, 8'hcc);
    lerr = 1'b1;
    acc(1'b0, OFS_ISR, 8'h00);
    chk("isr", q, 8'hc6);
    lerr = 1'b0;
    tmo = 1'b0;
    msrp = 1'b1;
    acc(1'b0, OFS_ISR, 8'h00);
    chk("isr", q, 8'hc0);
    msrp = 1'b0;
    $display("trigger test done");
    hold = 1'b1;
    repeat (6) @(negedge clk_i);
    acc(1'b0, OFS_ISR, 8'h00);
    chk("flow", q[5], 1'b1);
    msr_rd = 1'b1;
    @(negedge clk_i);
    msr_rd = 1'b0;
    acc(1'b0, OFS_ISR, 8'h00);
    chk("flow", q[5], 1'b0);
    acc(1'b1, OFS_MCR, 8'h02);
    acc(1'b1, OFS_MCR, 8'h00);
    repeat (2) @(negedge clk_i);
    acc(1'b0, OFS_ISR, 8'h00);
    chk("flow", q[5], 1'b1);
    $display("flow status test done");
    wrap_up();
  end
endmodule : ufl_ctrl_tb
`default_nettype wire
